// ---- hdl/fsp_flash_options.sv ----
// Flash option, configuration and protection shadow registers.
// Assumes one AHB-Lite master, nonvolatile bytes stable at reset release,
// and side-band flags telling debug and secure-code accesses apart.
//
// Notes on behaviour
// - Option shadow loads from nonvolatile byte at reset.
// - Backdoor enable low blocks any key unlock.
// - Key writes only from secure firmware, not debug.
// - Eight ascending matching bytes unsecure until reset.
// - Option bit 6 disables vector redirection.
// - Only code 1:0 means unsecured.
// - Secure device blocks unsecured memory accesses.
// - Key match or blank check sets unsecured.
// - Key access selects command start or key write.
// - Protection shadow loads from nonvolatile byte.
// - Protection shadow reads anytime without side effects.
// - Enabled protection accepts only smaller select.
// - Disabled protection ignores application writes.
// - Debug writes may change every protection bit.
// - Select field sets unprotected end address.
// - Program or erase refused in protected block.
// - Disable bit one means nothing protected.
// - Clearing key access triggers the key compare.
// - Each register is eight bits wide.
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_options #(
    parameter int KEY_N = fsp_pkg::KEY_BYTES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bus_from_debug,
    input wire logic bus_from_secure_code,
    input wire logic [7:0] nv_option_byte,
    input wire logic [7:0] nv_protect_byte,
    input wire logic [8*KEY_N-1:0] nv_backdoor_key,
    input wire logic blank_check_pass,
    input wire logic mem_req,
    input wire logic mem_req_unsecured,
    output logic mem_blocked,
    input wire logic pe_req,
    input wire logic [fsp_pkg::FLASH_ADDR_W-1:0] pe_addr,
    output logic pe_granted,
    output logic pe_refused,
    output logic cmd_start,
    output logic secure,
    output logic vector_redirect_disable,
    output logic protect_enable
);
    localparam int IDX_W = $clog2(KEY_N);

    fsp_pkg::fsp_phase_t phase_reg;
    logic [7:0] option_shadow_reg;
    logic [7:0] protect_shadow_reg;
    logic key_access_enable_reg;
    logic [1:0] security_code_reg;
    logic key_locked_reg;

    logic dp_valid_reg;
    logic dp_write_reg;
    logic dp_hit_reg;
    logic [7:0] dp_addr_reg;
    logic dp_debug_reg;
    logic dp_secure_reg;
    logic rd_pend_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;

    logic mem_blocked_reg;
    logic pe_granted_reg;
    logic pe_refused_reg;
    logic cmd_start_reg;
    logic secure_reg;
    logic redirect_off_reg;
    logic protect_enable_reg;

    logic addr_take;
    logic wr_now;
    logic wr_option;
    logic wr_config;
    logic wr_protect;
    logic is_key;
    logic [7:0] key_off;
    logic [IDX_W-1:0] key_idx;
    logic key_wr;
    logic key_trigger;
    logic key_clear;
    logic key_match;
    logic backdoor_enable;
    logic secure_now;
    logic [fsp_pkg::PROT_SEL_W-1:0] protect_select;
    logic protect_disable;
    logic prot_hit;
    logic [31:0] rd_mux;

    // Address phase is taken only when the previous transfer completes.
    assign addr_take = hsel && hready && htrans[1];
    assign wr_now = dp_valid_reg && dp_write_reg && dp_hit_reg;
    assign wr_option = wr_now && dp_addr_reg == fsp_pkg::ADDR_OPTION;
    assign wr_config = wr_now && dp_addr_reg == fsp_pkg::ADDR_CONFIG;
    assign wr_protect = wr_now && dp_addr_reg == fsp_pkg::ADDR_PROTECT;
    assign is_key = dp_addr_reg >= fsp_pkg::ADDR_KEY_BASE
        && dp_addr_reg <= fsp_pkg::ADDR_KEY_LAST
        && dp_addr_reg[1:0] == 2'h0;
    assign key_off = dp_addr_reg - fsp_pkg::ADDR_KEY_BASE;
    assign key_idx = key_off[IDX_W+1:2];

    assign backdoor_enable = option_shadow_reg[fsp_pkg::OPT_BACKDOOR_ENABLE_BIT];
    assign secure_now = security_code_reg != fsp_pkg::SEC_UNSECURED;
    assign protect_select = protect_shadow_reg[7:1];
    assign protect_disable = protect_shadow_reg[fsp_pkg::PROT_DIS_BIT];

    assign key_wr = wr_now && is_key && key_access_enable_reg
        && !dp_debug_reg && dp_secure_reg;
    assign key_trigger = wr_config && key_access_enable_reg
        && !hwdata[fsp_pkg::CFG_KEY_ACCESS_ENABLE_BIT];
    // A fresh attempt starts when key access is switched on.
    assign key_clear = key_trigger || (wr_config && !key_access_enable_reg
        && hwdata[fsp_pkg::CFG_KEY_ACCESS_ENABLE_BIT]);

    fsp_key_check #(
        .N_BYTES(KEY_N)
    ) u_key_check (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(key_clear),
        .wr(key_wr),
        .idx(key_idx),
        .data(hwdata[7:0]),
        .key(nv_backdoor_key),
        .match(key_match)
    );

    fsp_prot_range #(
        .ADDR_W(fsp_pkg::FLASH_ADDR_W),
        .SEL_W(fsp_pkg::PROT_SEL_W),
        .SHIFT(fsp_pkg::BLOCK_SHIFT)
    ) u_prot_range (
        .enable(!protect_disable),
        .sel(protect_select),
        .addr(pe_addr),
        .hit(prot_hit)
    );

    // The nonvolatile bytes are caught one edge after reset release,
    // since an asynchronous reset may only load constants.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= fsp_pkg::FSP_LOAD;
        end else begin
            case (phase_reg)
                fsp_pkg::FSP_LOAD: phase_reg <= fsp_pkg::FSP_RUN;
                fsp_pkg::FSP_RUN: phase_reg <= fsp_pkg::FSP_RUN;
                default: phase_reg <= fsp_pkg::FSP_LOAD;
            endcase
        end
    end

    // option copy
    // The shadow is read-only; writes to it are dropped, so only a reset
    // brings in a reprogrammed option byte.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            option_shadow_reg <= fsp_pkg::OPTION_RESET;
        end else if (phase_reg == fsp_pkg::FSP_LOAD) begin
            option_shadow_reg <= nv_option_byte;
        end
    end

    // unsecure events
    // The live code starts from the option byte; a key match or a blank
    // flash unsecures it, and nothing re-secures it before reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            security_code_reg <= fsp_pkg::SEC_RESET;
        end else if (phase_reg == fsp_pkg::FSP_LOAD) begin
            security_code_reg <= nv_option_byte[1:0];
        end else if (blank_check_pass) begin
            security_code_reg <= fsp_pkg::SEC_UNSECURED;
        end else if (key_trigger && backdoor_enable && !key_locked_reg
                && key_match) begin
            security_code_reg <= fsp_pkg::SEC_UNSECURED;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_locked_reg <= 1'b0;
        end else if (key_trigger && backdoor_enable && !key_match) begin
            key_locked_reg <= 1'b1;
        end
    end

    // Only the key access bit of the configuration register is held.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_access_enable_reg <= fsp_pkg::CONFIG_RESET[5];
        end else if (wr_config) begin
            key_access_enable_reg <= hwdata[fsp_pkg::CFG_KEY_ACCESS_ENABLE_BIT];
        end
    end

    // protect copy
    // Application writes can only shrink the select field; a debug write
    // is trusted and may rewrite the whole byte.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protect_shadow_reg <= fsp_pkg::PROTECT_RESET;
        end else if (phase_reg == fsp_pkg::FSP_LOAD) begin
            protect_shadow_reg <= nv_protect_byte;
        end else if (wr_protect) begin
            if (dp_debug_reg) begin
                protect_shadow_reg <= hwdata[7:0];
            end else if (!protect_disable
                    && hwdata[7:1] < protect_select) begin
                protect_shadow_reg[7:1] <= hwdata[7:1];
            end
        end
    end

    // Address phase capture; only a word decode below 256 bytes hits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_hit_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            dp_debug_reg <= 1'b0;
            dp_secure_reg <= 1'b0;
        end else if (hready) begin
            dp_valid_reg <= addr_take;
            dp_write_reg <= hwrite;
            dp_hit_reg <= haddr[31:8] == fsp_pkg::HADDR_HIGH_ZERO;
            dp_addr_reg <= haddr[7:0];
            dp_debug_reg <= bus_from_debug;
            dp_secure_reg <= bus_from_secure_code;
        end
    end

    // plain readback
    // Reserved bits read as zero; reads change no state.
    always_comb begin
        rd_mux = 32'h00000000;
        if (dp_hit_reg) begin
            case (dp_addr_reg)
                fsp_pkg::ADDR_OPTION: begin
                    rd_mux[7:6] = option_shadow_reg[7:6];
                    rd_mux[1:0] = security_code_reg;
                end
                fsp_pkg::ADDR_CONFIG: begin
                    rd_mux[fsp_pkg::CFG_KEY_ACCESS_ENABLE_BIT] =
                        key_access_enable_reg;
                end
                fsp_pkg::ADDR_PROTECT: rd_mux[7:0] = protect_shadow_reg;
                fsp_pkg::ADDR_STATUS: begin
                    rd_mux[fsp_pkg::ST_SECURE_BIT] = secure_now;
                    rd_mux[fsp_pkg::ST_LOCKED_BIT] = key_locked_reg;
                    rd_mux[fsp_pkg::ST_MATCH_BIT] = key_match;
                end
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // Reads take one wait state so read data comes from a flip-flop and
    // already reflects a write finished in the cycle before.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h00000000;
        end else if (addr_take && !hwrite) begin
            rd_pend_reg <= 1'b1;
            hreadyout_reg <= 1'b0;
        end else if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= rd_mux;
        end
    end

    // command start
    // With key access off, a key-location write is a flash command start.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_start_reg <= 1'b0;
        end else begin
            cmd_start_reg <= wr_now && is_key && !key_access_enable_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_blocked_reg <= 1'b0;
        end else begin
            mem_blocked_reg <= mem_req && mem_req_unsecured && secure_now;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pe_granted_reg <= 1'b0;
            pe_refused_reg <= 1'b0;
        end else begin
            pe_granted_reg <= pe_req && !prot_hit;
            pe_refused_reg <= pe_req && prot_hit;
        end
    end

    // redirect control
    // Level outputs are registered copies of the live state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            secure_reg <= 1'b1;
            redirect_off_reg <= 1'b0;
            protect_enable_reg <= 1'b0;
        end else begin
            secure_reg <= secure_now;
            redirect_off_reg <= option_shadow_reg[fsp_pkg::OPT_NORED_BIT];
            protect_enable_reg <= !protect_disable;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = fsp_pkg::HRESP_OKAY;
    assign mem_blocked = mem_blocked_reg;
    assign pe_granted = pe_granted_reg;
    assign pe_refused = pe_refused_reg;
    assign cmd_start = cmd_start_reg;
    assign secure = secure_reg;
    assign vector_redirect_disable = redirect_off_reg;
    assign protect_enable = protect_enable_reg;
endmodule : fsp_flash_options
`default_nettype wire

// ---- hdl/fsp_key_check.sv ----
// Collects backdoor key bytes in ascending order and compares them.
// Assumes the caller qualifies each write and clears it before a try.
`timescale 1ns/1ps
`default_nettype none
module fsp_key_check #(
    parameter int N_BYTES = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic wr,
    input wire logic [$clog2(N_BYTES)-1:0] idx,
    input wire logic [7:0] data,
    input wire logic [8*N_BYTES-1:0] key,
    output logic match
);
    logic [$clog2(N_BYTES):0] count_reg;
    logic bad_reg;

    // An out-of-order or wrong byte spoils the whole attempt.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
            bad_reg <= 1'b0;
        end else if (clear) begin
            count_reg <= '0;
            bad_reg <= 1'b0;
        end else if (wr) begin
            if (count_reg < ($clog2(N_BYTES)+1)'(N_BYTES)
                    && {1'b0, idx} == count_reg
                    && data == key[8*idx +: 8]) begin
                count_reg <= count_reg + 1'b1;
            end else begin
                bad_reg <= 1'b1;
            end
        end
    end

    // Match only after every byte arrived once and in order.
    assign match = !bad_reg
        && count_reg == ($clog2(N_BYTES)+1)'(N_BYTES);
endmodule : fsp_key_check
`default_nettype wire

// ---- hdl/fsp_prot_range.sv ----
// Decides whether a flash address lies in the protected top block.
// Assumes whole blocks of 2**SHIFT bytes at the high address end.
`timescale 1ns/1ps
`default_nettype none
module fsp_prot_range #(
    parameter int ADDR_W = 16,
    parameter int SEL_W = 7,
    parameter int SHIFT = 9
) (
    input wire logic enable,
    input wire logic [SEL_W-1:0] sel,
    input wire logic [ADDR_W-1:0] addr,
    output logic hit
);
    logic [ADDR_W-1:0] last_free;

    // The select field names the last unprotected block.
    assign last_free = ADDR_W'({sel, {SHIFT{1'b1}}});
    assign hit = enable && (addr > last_free);
endmodule : fsp_prot_range
`default_nettype wire

// ---- include/fsp_pkg.sv ----
// Package for the flash security and protection option block.
// Assumes a 32-bit AHB-Lite register bus and 8-bit option registers.
package fsp_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] ADDR_OPTION = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_PROTECT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_KEY_BASE = 8'h10;
    localparam logic [7:0] ADDR_KEY_LAST = 8'h2C;
    // Field positions.
    localparam int OPT_BACKDOOR_ENABLE_BIT = 7;
    localparam int OPT_NORED_BIT = 6;
    localparam int CFG_KEY_ACCESS_ENABLE_BIT = 5;
    localparam int PROT_DIS_BIT = 0;
    localparam int ST_SECURE_BIT = 0;
    localparam int ST_LOCKED_BIT = 1;
    localparam int ST_MATCH_BIT = 2;
    // Security code values.
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [1:0] SEC_RESET = 2'h3;
    // Reset values held until the nonvolatile bytes are copied in, or for the configuration until a bus write.
    localparam logic [7:0] OPTION_RESET = 8'h03;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PROTECT_RESET = 8'hFF;
    // Flash geometry and key size.
    localparam int KEY_BYTES = 8;
    localparam int PROT_SEL_W = 7;
    localparam int FLASH_ADDR_W = 16;
    localparam int BLOCK_SHIFT = 9;
    // Bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [23:0] HADDR_HIGH_ZERO = 24'h000000;
    // Load phase after reset release.
    typedef enum logic {
        FSP_LOAD,
        FSP_RUN
    } fsp_phase_t;
endpackage : fsp_pkg

// ---- verif/fsp_flash_options_asserts.sv ----
// Timing checks on the option block's bus and side-band ports.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_options_asserts #(
    parameter int KEY_N = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic blank_check_pass,
    input wire logic mem_req,
    input wire logic mem_req_unsecured,
    input wire logic mem_blocked,
    input wire logic pe_req,
    input wire logic pe_granted,
    input wire logic pe_refused,
    input wire logic secure,
    input wire logic vector_redirect_disable,
    input wire logic protect_enable
);
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Address phases of reads and writes, and the single read wait.
    sequence s_rd_addr;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_wr_addr;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait: assert property (s_rd_addr |=> s_one_wait)
        else $error("read did not take exactly one wait state");
    a_write_nowait: assert property (s_wr_addr |=> hreadyout)
        else $error("write stalled the bus");
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("response not okay");
    // The secure output and the block flag both lag the live code by one
    // cycle, so the request is paired with secure as seen one edge later.
    a_mem_block: assert property (
        mem_req && mem_req_unsecured ##1 secure |-> mem_blocked)
        else $error("unsecured access not blocked");
    a_mem_free: assert property (!mem_req |=> !mem_blocked)
        else $error("block raised without a request");
    a_pe_onehot: assert property (
        pe_req |=> pe_granted != pe_refused)
        else $error("program request not answered once");
    a_pe_idle: assert property (
        !pe_req |=> !pe_granted && !pe_refused)
        else $error("program answer without request");
    a_pe_noprot: assert property (
        pe_req && !protect_enable |=> pe_granted)
        else $error("refused while protection disabled");
    a_secure_sticky: assert property (!secure |=> !secure)
        else $error("security re-engaged before reset");
    a_blank_unsec: assert property (
        blank_check_pass |-> ##[1:2] !secure)
        else $error("blank check did not unsecure");
    // The output settles on the second edge after release, so the check
    // starts only when reset was already high three sampled edges earlier.
    a_vrd_stable: assert property (
        $past(hresetn, 3) |-> $stable(vector_redirect_disable))
        else $error("redirect disable changed after load");
endmodule : fsp_flash_options_asserts
bind fsp_flash_options fsp_flash_options_asserts #(.KEY_N(KEY_N)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .blank_check_pass(blank_check_pass),
    .mem_req(mem_req), .mem_req_unsecured(mem_req_unsecured),
    .mem_blocked(mem_blocked), .pe_req(pe_req), .pe_granted(pe_granted),
    .pe_refused(pe_refused), .secure(secure),
    .vector_redirect_disable(vector_redirect_disable),
    .protect_enable(protect_enable)
);
`default_nettype wire

// ---- verif/fsp_flash_options_tb.sv ----
// Self-checking bench for the flash option and protection block.
// Assumes the host model drives the bus and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            err_total++; \
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
        end \
    end
module fsp_flash_options_tb;
    typedef struct packed {
        logic [7:0] opt;
        logic [7:0] prot;
        logic sec;
        logic vrd;
        logic pen;
    } fsp_row_t;
    localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
    fsp_row_t rows [4] = '{'{8'h00, 8'hFF, 1'h1, 1'h0, 1'h0},
        '{8'h41, 8'h80, 1'h1, 1'h1, 1'h1},
        '{8'hC2, 8'h7F, 1'h0, 1'h1, 1'h0},
        '{8'h83, 8'h20, 1'h1, 1'h0, 1'h1}};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dbg, secf;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] nvo, nvp;
    logic [15:0] peaddr;
    logic blank, mreq, munsec, mblk, pereq, pegr, peref, cmd;
    logic secure, vrd, pen;
    int err_total = 0;
    int n_tests = 0;
    int ncmd = 0;

    fsp_host_model host_u (.hclk(hclk), .hreadyout(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .bus_from_debug(dbg), .bus_from_secure_code(secf));
    fsp_flash_options dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bus_from_debug(dbg),
        .bus_from_secure_code(secf), .nv_option_byte(nvo),
        .nv_protect_byte(nvp), .nv_backdoor_key(KEY),
        .blank_check_pass(blank), .mem_req(mreq),
        .mem_req_unsecured(munsec), .mem_blocked(mblk), .pe_req(pereq),
        .pe_addr(peaddr), .pe_granted(pegr), .pe_refused(peref),
        .cmd_start(cmd), .secure(secure), .vector_redirect_disable(vrd),
        .protect_enable(pen));

    // Free-running 100 MHz bus clock.
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end

    // Counts command-start pulses so stray ones are noticed too.
    always @(posedge hclk) begin
        if (cmd === 1'h1) begin
            ncmd++;
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // a new option takes effect only through a fresh reset.
    task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
        @(posedge hclk);
        nvo <= o;
        nvp <= p;
        hresetn <= 1'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (3) @(posedge hclk);
    endtask : do_reset

    task automatic pw(input logic [7:0] d, input logic g, input logic [7:0] ex);
        host_u.xfer(1'h1, fsp_pkg::ADDR_PROTECT, d, g, rd);
        host_u.xfer(1'h0, fsp_pkg::ADDR_PROTECT, 8'h00, 1'h0, rd);
        `CHK("protect", {24'h000000, ex}, rd)
    endtask : pw

    task automatic pe(input logic [15:0] a, input logic g);
        @(posedge hclk);
        pereq <= 1'h1;
        peaddr <= a;
        @(posedge hclk);
        pereq <= 1'h0;
        @(posedge hclk);
        `CHK("granted", g, pegr)
        `CHK("refused", !g, peref)
    endtask : pe

    // Hung runs end here; the span is far beyond the whole sequence.
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        test_done();
    end

    initial begin
        {hresetn, blank, mreq, munsec, pereq} = 5'h00;
        {nvo, nvp, peaddr} = 32'h0000FF00;
        repeat (2) @(posedge hclk);
        `CHK("secure", 1'h1, secure)
        foreach (rows[i]) begin
            do_reset(rows[i].opt, rows[i].prot);
            `CHK("secure", rows[i].sec, secure)
            `CHK("redirect", rows[i].vrd, vrd)
            `CHK("prot_en", rows[i].pen, pen)
            host_u.xfer(1'h0, fsp_pkg::ADDR_OPTION, 8'h00, 1'h0, rd);
            `CHK("option", {24'h000000, rows[i].opt}, rd)
            host_u.xfer(1'h0, fsp_pkg::ADDR_PROTECT, 8'h00, 1'h0, rd);
            `CHK("protect", {24'h000000, rows[i].prot}, rd)
        end
        host_u.xfer(1'h0, 8'h40, 8'h00, 1'h0, rd);
        `CHK("unmapped", 32'h00000000, rd)
        // Good key, key disabled, key from debug, bad key then good.
        for (int i = 0; i < 4; i++) begin
            do_reset(i == 1 ? 8'h03 : 8'h83, 8'hFF);
            if (i == 3) host_u.unlock(~KEY, 1'h0);
            host_u.unlock(KEY, i == 2);
            repeat (3) @(posedge hclk);
            `CHK("secure", i != 0, secure)
        end
        // Last attempt was locked out: secure and locked, no bytes held.
        host_u.xfer(1'h0, fsp_pkg::ADDR_STATUS, 8'h00, 1'h0, rd);
        `CHK("status", 32'h00000003, rd)
        `CHK("cmd_count", 0, ncmd)
        host_u.xfer(1'h1, fsp_pkg::ADDR_KEY_BASE, 8'h55, 1'h0, rd);
        repeat (3) @(posedge hclk);
        `CHK("cmd_count", 1, ncmd)
        // Blocked while secure, free once the blank check unsecures.
        do_reset(8'h83, 8'hFF);
        {mreq, munsec} <= 2'h3;
        repeat (2) @(posedge hclk);
        `CHK("blocked", 1'h1, mblk)
        blank <= 1'h1;
        @(posedge hclk);
        blank <= 1'h0;
        repeat (3) @(posedge hclk);
        `CHK("secure", 1'h0, secure)
        `CHK("blocked", 1'h0, mblk)
        mreq <= 1'h0;
        do_reset(8'h83, 8'h80);
        pw(8'h90, 1'h0, 8'h80);
        pw(8'h60, 1'h0, 8'h60);
        pw(8'h61, 1'h0, 8'h60);
        pe(16'h61FF, 1'h1);
        pe(16'h6200, 1'h0);
        pw(8'hFF, 1'h1, 8'hFF);
        pe(16'hFFFF, 1'h1);
        pw(8'h20, 1'h0, 8'hFF);
        test_done();
    end
endmodule : fsp_flash_options_tb
`default_nettype wire

// ---- verif/fsp_host_model.sv ----
// Bus master standing in for user firmware and the debug port.
// Assumes one slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model (
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic bus_from_debug,
    output logic bus_from_secure_code
);
    // The bus idles with no transfer pending.
    initial begin
        hsel = 1'h0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        bus_from_debug = 1'h0;
        bus_from_secure_code = 1'h1;
    end

    // source flags ride the address phase.
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [7:0] d, input logic dbg,
            output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        bus_from_debug <= dbg;
        bus_from_secure_code <= !dbg;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        // Released data lines flip so a stale value can never pass.
        hwdata <= ~hwdata;
    endtask : xfer

    // ascending key bytes, then access closed.
    task automatic unlock(input logic [63:0] key, input logic dbg);
        logic [31:0] rd;
        xfer(1'h1, fsp_pkg::ADDR_CONFIG, 8'h20, 1'h0, rd);
        for (int i = 0; i < 8; i++) begin
            xfer(1'h1, fsp_pkg::ADDR_KEY_BASE + 8'(4 * i),
                key[8*i +: 8], dbg, rd);
        end
        xfer(1'h1, fsp_pkg::ADDR_CONFIG, 8'h00, 1'h0, rd);
    endtask : unlock
endmodule : fsp_host_model
`default_nettype wire
